// ---- src/spi_regport_pkg.sv ----
package spi_regport_pkg;

   // geometry
   localparam int NUM_REGS = 128;
   localparam int ADDR_W   = 7;
   localparam int DATA_W   = 8;
   localparam int CNT_W    = 6;
   localparam int MAX_DATA = 3;

   // frame lengths in bits
   localparam logic [5:0] LEN_ONE   = 6'h10;
   localparam logic [5:0] LEN_TWO   = 6'h18;
   localparam logic [5:0] LEN_THREE = 6'h20;
   localparam logic [5:0] CNT_SAT   = 6'h3f;
   localparam logic [5:0] CMD_BITS  = 6'h08;

   // field positions
   localparam int RD_ONLY_BIT   = 0;
   localparam int SER_FAIL_BIT  = 1;
   localparam int MODE_LSB      = 0;
   localparam int MODE_W        = 3;
   localparam int LOCK_FIRST    = 1;
   localparam int LOCK_BITS     = 7;

   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [7:0] FIRST_BYTE = 8'h00;

   // register offsets
   localparam logic [6:0] A_MODE_CTRL   = 7'h01;
   localparam logic [6:0] A_REG_LEVEL   = 7'h02;
   localparam logic [6:0] A_MODE_STAT   = 7'h03;
   localparam logic [6:0] A_SYS_EN      = 7'h04;
   localparam logic [6:0] A_REG_EV_EN   = 7'h05;
   localparam logic [6:0] A_GENERAL_PURPOSE_MEMORY_0        = 7'h06;
   localparam logic [6:0] A_GENERAL_PURPOSE_MEMORY_3        = 7'h09;
   localparam logic [6:0] A_WR_LOCK     = 7'h0a;
   localparam logic [6:0] A_CAN_CTRL    = 7'h20;
   localparam logic [6:0] A_LIN_CTRL    = 7'h21;
   localparam logic [6:0] A_CAN_STAT    = 7'h22;
   localparam logic [6:0] A_TRX_EV_EN   = 7'h23;
   localparam logic [6:0] A_LIN_STAT    = 7'h24;
   localparam logic [6:0] A_REG_EN      = 7'h25;
   localparam logic [6:0] A_WAKE_RATE   = 7'h26;
   localparam logic [6:0] A_WID0        = 7'h27;
   localparam logic [6:0] A_WID2        = 7'h29;
   localparam logic [6:0] A_WID3        = 7'h2a;
   localparam logic [6:0] A_WIDM0       = 7'h2b;
   localparam logic [6:0] A_WIDM2       = 7'h2d;
   localparam logic [6:0] A_WIDM3       = 7'h2e;
   localparam logic [6:0] A_WFMT        = 7'h2f;
   localparam logic [6:0] A_BF_EN       = 7'h32;
   localparam logic [6:0] A_BF_IND      = 7'h33;
   localparam logic [6:0] A_CLAMP_EN    = 7'h34;
   localparam logic [6:0] A_CLAMP_EV    = 7'h35;
   localparam logic [6:0] A_WD_CTRL1    = 7'h36;
   localparam logic [6:0] A_WD_CTRL2    = 7'h37;
   localparam logic [6:0] A_WD_STAT     = 7'h38;
   localparam logic [6:0] A_WD_SERVICE  = 7'h39;
   localparam logic [6:0] A_FE_THRESH   = 7'h3a;
   localparam logic [6:0] A_FE_COUNT    = 7'h3b;
   localparam logic [6:0] A_PIN_WAKE    = 7'h4b;
   localparam logic [6:0] A_LWAKE_EN    = 7'h4c;
   localparam logic [6:0] A_GLOBAL_EV   = 7'h60;
   localparam logic [6:0] A_SYS_EV      = 7'h61;
   localparam logic [6:0] A_LIN_EV      = 7'h62;
   localparam logic [6:0] A_CAN_EV      = 7'h63;
   localparam logic [6:0] A_LWAKE_EV    = 7'h64;
   localparam logic [6:0] A_BF_EV       = 7'h65;
   localparam logic [6:0] A_REG_EV      = 7'h66;
   localparam logic [6:0] A_GLITCH      = 7'h67;
   localparam logic [6:0] A_PMASK0      = 7'h68;
   localparam logic [6:0] A_PMASK1      = 7'h69;

   // read-only state supplied by the rest of the device
   typedef struct packed {
      logic [7:0] mode_status;
      logic [7:0] can_status;
      logic [7:0] lin_status;
      logic [7:0] bus_fault;
      logic [7:0] wd_status;
      logic [7:0] pin_wake;
      logic [7:0] global_summary;
   } ro_status_t;

   // one-cycle event set pulses for the sticky status registers
   typedef struct packed {
      logic [7:0] clamp;
      logic [7:0] system;
      logic [7:0] lin;
      logic [7:0] can;
      logic [7:0] local_wake;
      logic [7:0] bus_fault;
      logic [7:0] regulator;
   } event_set_t;

endpackage

// ---- src/spi_register_access_port.sv ----
// Contract
// - sample input on falling serial clock edge, change output on rising edge
// - registers are 8 bits wide, each selected by a 7-bit address
// - first byte is address plus read-only flag; 1 means read, data ignored
// - addressed register contents shift out while host shifts bytes in
// - address auto-increments once per extra data byte in 24/32-bit frames
// - first byte returned on serial output is always 0x00
// - writes beyond valid registers are discarded without raising failure
// - frame length other than 16, 24 or 32 bits aborts with no write
// - if enabled, length error, illegal mode or locked write sets failure flag
// - read longer than 32 bits echoes serial input on output from bit 33
// - address space of 128 registers, 0x00 to 0x7f
// - a read-only command of valid length changes no register
`timescale 1ns/1ps
module spi_register_access_port #(
   parameter logic [7:0] LEGAL_MODE_MASK = 8'h96
) (
   // system clock and reset
   input  wire logic                         clk_sys_i,
   input  wire logic                         rst_i,
   input  wire logic                         clk_en_i,
   // serial link, clocked by the host
   input  wire logic                         sclk_i,
   input  wire logic                         chip_select_n_i,
   input  wire logic                         sdi_i,
   output logic                              sdo_o,
   output logic                              sdo_oe_o,
   // device state and events
   input  wire spi_regport_pkg::ro_status_t  ro_status_i,
   input  wire spi_regport_pkg::event_set_t  event_set_i,
   // register image and failure flag
   output logic [1023:0]                     reg_image_o,
   output logic                              serial_failure_flag_o
);
   import spi_regport_pkg::*;

   // link-domain frame capture
   logic [CNT_W-1:0]  cnt_q;
   logic              started_q;
   logic              frame_tog_q;
   logic [7:0]        shift_q;
   logic [7:0]        cmd_q;
   logic [7:0]        data_q [MAX_DATA];
   logic              sdo_q;
   logic [CNT_W-1:0]  cnt_d;

   // system-domain state
   logic [NUM_REGS-1:0][DATA_W-1:0] regs_q;
   logic [NUM_REGS-1:0][DATA_W-1:0] regs_d;
   logic              cs_meta_q;
   logic              cs_sync_q;
   logic              cs_prev_q;
   logic              tog_meta_q;
   logic              tog_sync_q;
   logic              tog_seen_q;
   logic              oe_q;
   event_set_t        pend_q;
   event_set_t        ev_now;
   logic              busy;
   logic              frame_end;
   logic              len_ok;
   logic [1:0]        nbytes;
   logic              rd_only;
   logic              fail_evt;

   // writable bit mask per address; zero for read-only or absent
   function automatic logic [7:0] wmask(input logic [6:0] a);
      logic [7:0] m;
      m = 8'h00;
      unique case (a)
         A_MODE_CTRL:                    m = 8'h3f;
         A_REG_LEVEL:                    m = 8'h07;
         A_SYS_EN:                       m = 8'h4f;
         A_REG_EV_EN:                    m = 8'h7f;
         A_WR_LOCK:                      m = 8'h7f;
         A_CAN_CTRL:                     m = 8'h73;
         A_LIN_CTRL:                     m = 8'h03;
         A_REG_EN:                       m = 8'h03;
         A_TRX_EV_EN:                    m = 8'h57;
         A_WAKE_RATE:                    m = 8'h0f;
         A_WID3:                         m = 8'h1f;
         A_WIDM3:                        m = 8'h1f;
         A_WFMT:                         m = 8'hcf;
         A_BF_EN:                        m = 8'h03;
         A_BF_EV:                        m = 8'h03;
         A_CLAMP_EN:                     m = 8'h01;
         A_CLAMP_EV:                     m = 8'h01;
         A_WD_CTRL1:                     m = 8'hfe;
         A_WD_CTRL2:                     m = 8'hff;
         A_WD_SERVICE:                   m = 8'hff;
         A_FE_THRESH:                    m = 8'h1f;
         A_FE_COUNT:                     m = 8'h1f;
         A_LWAKE_EN:                     m = 8'h07;
         A_LWAKE_EV:                     m = 8'h07;
         A_SYS_EV:                       m = 8'hd3;
         A_LIN_EV:                       m = 8'h0f;
         A_CAN_EV:                       m = 8'h7f;
         A_REG_EV:                       m = 8'hff;
         A_PMASK0:                       m = 8'hff;
         A_PMASK1:                       m = 8'hff;
         A_GLITCH:                       m = 8'h07;
         default: begin
            if ((a >= A_GENERAL_PURPOSE_MEMORY_0 && a <= A_GENERAL_PURPOSE_MEMORY_3) ||
                (a >= A_WID0 && a <= A_WID2) ||
                (a >= A_WIDM0 && a <= A_WIDM2)) begin
               m = 8'hff;
            end
         end
      endcase
      return m;
   endfunction

   // sticky, write-one-to-clear registers
   function automatic logic is_w1c(input logic [6:0] a);
      return (a == A_CLAMP_EV) || (a >= A_SYS_EV && a <= A_REG_EV);
   endfunction

   // address of data byte k; bit 7 set means past the top of the map
   function automatic logic [7:0] next_addr(input logic [7:0] c,
                                            input logic [1:0] k);
      return {1'b0, c[7:1]} + {6'h00, k};
   endfunction

   // bit p of a byte, counted from the msb
   function automatic logic msb_pick(input logic [7:0] b,
                                     input logic [2:0] p);
      return b[3'h7 - p];
   endfunction

   // data bytes carried by a frame of this many bits; zero is an error
   function automatic logic [1:0] len_bytes(input logic [5:0] n);
      logic [1:0] b;
      b = 2'h0;
      unique case (n)
         LEN_ONE:   b = 2'h1;
         LEN_TWO:   b = 2'h2;
         LEN_THREE: b = 2'h3;
         default:   b = 2'h0;
      endcase
      return b;
   endfunction

   // lock bit n guards address LOCK_FIRST + n
   function automatic logic locked(input logic [6:0] r,
                                   input logic [7:0] lk);
      logic [6:0] n;
      n = r - 7'(LOCK_FIRST);
      return (r >= 7'(LOCK_FIRST)) && (n < 7'(LOCK_BITS)) && lk[n[2:0]];
   endfunction

   // operating mode codes outside the legal set are refused
   function automatic logic mode_ok(input logic [7:0] d);
      return LEGAL_MODE_MASK[d[MODE_LSB +: MODE_W]];
   endfunction

   // event pulses that land in each sticky register
   function automatic logic [7:0] ev_bits(input logic [6:0] a,
                                          input event_set_t e);
      logic [7:0] b;
      b = 8'h00;
      unique case (a)
         A_CLAMP_EV: b = e.clamp;
         A_SYS_EV:   b = e.system;
         A_LIN_EV:   b = e.lin;
         A_CAN_EV:   b = e.can;
         A_LWAKE_EV: b = e.local_wake;
         A_BF_EV:    b = e.bus_fault;
         A_REG_EV:   b = e.regulator;
         default:    b = 8'h00;
      endcase
      // undefined bits never latch, so a clear always empties them
      return b & wmask(a);
   endfunction

   // ---------------- link domain ----------------

   // cleared by chip select so a new frame starts clean
   always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         started_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
      end
   end

   always_comb begin
      if (!started_q) begin
         cnt_d = 6'h01;
      end else if (cnt_q != CNT_SAT) begin
         cnt_d = cnt_q + 6'h01;
      end else begin
         cnt_d = cnt_q;
      end
   end

   // bits are counted only between assertion and deassertion
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q       <= '0;
         frame_tog_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         if (!started_q) begin
            frame_tog_q <= ~frame_tog_q;
         end
      end
   end

   // input sampled on the falling edge, msb first
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_q <= '0;
      end else begin
         shift_q <= {shift_q[6:0], sdi_i};
      end
   end

   // whole bytes of the frame; bytes past the fourth are not kept
   always_ff @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_q <= '0;
         for (int i = 0; i < MAX_DATA; i++) begin
            data_q[i] <= '0;
         end
      end else if (cnt_d[2:0] == 3'h0 && cnt_d <= LEN_THREE) begin
         if (cnt_d == CMD_BITS) begin
            cmd_q <= {shift_q[6:0], sdi_i};
         end else begin
            data_q[cnt_d[4:3] - 2'h2] <= {shift_q[6:0], sdi_i};
         end
      end
   end

   // output changes on the rising edge
   // register array changes only after a frame, so reading it here is
   // stable while chip select is low; status is frozen during frames
   always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
      logic [7:0] a;
      logic [7:0] byte_v;
      a = 8'h00;
      byte_v = 8'h00;
      if (chip_select_n_i) begin
         sdo_q <= 1'b0;
      end else if (!started_q || cnt_q < CMD_BITS) begin
         sdo_q <= msb_pick(FIRST_BYTE, cnt_q[2:0]);
      end else if (cnt_q >= LEN_THREE) begin
         // loop back of the input stream on long reads
         sdo_q <= cmd_q[RD_ONLY_BIT] ? shift_q[0] : 1'b0;
      end else begin
         // address advances per data byte
         a = next_addr(cmd_q, cnt_q[4:3] - 2'h1);
         byte_v = a[7] ? 8'h00 : regs_q[a[6:0]];
         sdo_q <= msb_pick(byte_v, cnt_q[2:0]);
      end
   end

   assign sdo_o = sdo_q;

   // ---------------- system domain ----------------

   // chip select and frame toggle pass two flops before use
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cs_meta_q  <= 1'b1;
         cs_sync_q  <= 1'b1;
         cs_prev_q  <= 1'b1;
         tog_meta_q <= 1'b0;
         tog_sync_q <= 1'b0;
         tog_seen_q <= 1'b0;
      end else if (clk_en_i) begin
         cs_meta_q  <= chip_select_n_i;
         cs_sync_q  <= cs_meta_q;
         cs_prev_q  <= cs_sync_q;
         tog_meta_q <= frame_tog_q;
         tog_sync_q <= tog_meta_q;
         if (frame_end) begin
            tog_seen_q <= tog_sync_q;
         end
      end
   end

   assign busy      = ~cs_sync_q;
   assign frame_end = cs_sync_q & ~cs_prev_q;

   // output driven only inside a frame
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         oe_q <= 1'b0;
      end else if (clk_en_i) begin
         oe_q <= busy;
      end
   end

   assign sdo_oe_o = oe_q;

   // events during a frame wait so the read image stays still
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pend_q <= '0;
      end else if (clk_en_i) begin
         pend_q <= busy ? (pend_q | event_set_i) : '0;
      end
   end

   assign ev_now = busy ? '0 : (pend_q | event_set_i);

   // length check; a frame with no clock edge counts as an error
   always_comb begin
      nbytes = 2'h0;
      if (tog_sync_q != tog_seen_q) begin
         nbytes = len_bytes(cnt_q);
      end
      len_ok  = nbytes != 2'h0;
      rd_only = cmd_q[RD_ONLY_BIT];
   end

   // next register image: status load, frame writes, sticky events
   always_comb begin
      logic [7:0] a;
      logic [6:0] r;
      logic [7:0] d;
      logic       bad;
      a        = 8'h00;
      r        = 7'h00;
      d        = 8'h00;
      bad      = ~len_ok;
      regs_d   = regs_q;
      if (!busy) begin
         regs_d[A_MODE_STAT] = ro_status_i.mode_status;
         regs_d[A_CAN_STAT]  = ro_status_i.can_status;
         regs_d[A_LIN_STAT]  = ro_status_i.lin_status;
         regs_d[A_BF_IND]    = ro_status_i.bus_fault;
         regs_d[A_WD_STAT]   = ro_status_i.wd_status;
         regs_d[A_PIN_WAKE]  = ro_status_i.pin_wake;
         regs_d[A_GLOBAL_EV] = ro_status_i.global_summary;
      end
      // writes land only at deassertion of a valid frame
      if (frame_end && len_ok && !rd_only) begin
         for (int j = 0; j < MAX_DATA; j++) begin
            a = next_addr(cmd_q, 2'(j));
            r = a[6:0];
            d = data_q[j];
            if (2'(j) < nbytes && !a[7] && wmask(r) != 8'h00) begin
               if (locked(r, regs_q[A_WR_LOCK])) begin
                  bad = 1'b1;
               end else if (r == A_MODE_CTRL && !mode_ok(d)) begin
                  bad = 1'b1;
               end else if (is_w1c(r)) begin
                  regs_d[r] = regs_q[r] & ~(d & wmask(r));
               end else begin
                  regs_d[r] = d & wmask(r);
               end
            end
            // absent or out-of-range addresses fall through silently
         end
      end
      // hardware sets win over a clear in the same cycle
      for (int k = 0; k < NUM_REGS; k++) begin
         if (is_w1c(7'(k))) begin
            regs_d[k] = regs_d[k] | ev_bits(7'(k), ev_now);
         end
      end
      fail_evt = frame_end & bad & regs_q[A_SYS_EN][SER_FAIL_BIT];
      if (fail_evt) begin
         regs_d[A_SYS_EV][SER_FAIL_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         regs_q <= {NUM_REGS{RST_VAL}};
      end else if (clk_en_i) begin
         regs_q <= regs_d;
      end
   end

   assign reg_image_o           = regs_q;
   assign serial_failure_flag_o = regs_q[A_SYS_EV][SER_FAIL_BIT];

endmodule

// ---- test/spi_regport_props.sv ----
`timescale 1ns/1ps
module spi_regport_props (
   // clock and reset
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   // serial link
   input  wire logic          sclk_i,
   input  wire logic          chip_select_n_i,
   input  wire logic          sdi_i,
   input  wire logic          sdo_o,
   input  wire logic          sdo_oe_o,
   // register side
   input  wire logic [1023:0] reg_image_o,
   input  wire logic          serial_failure_flag_o
);
   logic [5:0] bits_q;
   logic       rd_q;

   // bit position in the frame; saturates so long echoes stay counted
   always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         bits_q <= 6'h00;
         rd_q   <= 1'b0;
      end else begin
         if (bits_q != 6'h3f)
            bits_q <= bits_q + 6'h01;
         if (bits_q == 6'h07)
            rd_q <= sdi_i;
      end
   end

   sdo_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      chip_select_n_i [*3] |-> !sdo_o) else $error("sdo busy while idle");
   oe_lag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sdo_oe_o == !$past(chip_select_n_i, 3)) else $error("sdo enable off");
   first_byte_a: assert property (@(negedge sclk_i) disable iff (rst_i)
      !chip_select_n_i && bits_q < 6'h08 |-> !sdo_o)
      else $error("first byte not zero");
   echo_a: assert property (@(negedge sclk_i) disable iff (rst_i)
      rd_q && bits_q >= 6'h20 |-> sdo_o == $past(sdi_i))
      else $error("read tail not echoed");
   write_tail_a: assert property (@(negedge sclk_i) disable iff (rst_i)
      !rd_q && bits_q >= 6'h20 |-> !sdo_o) else $error("write tail not zero");
   flag_rise_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(serial_failure_flag_o) |-> chip_select_n_i
         && $past(chip_select_n_i, 2)) else $error("flag set inside frame");
   frame_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !chip_select_n_i [*6] |-> $stable(reg_image_o))
      else $error("registers moved inside frame");
   reset_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(rst_i) |-> reg_image_o == '0 && !serial_failure_flag_o
         && !sdo_oe_o) else $error("state not cleared by reset");
endmodule

bind spi_register_access_port spi_regport_props chk_u (
   .clk_sys_i, .rst_i, .sclk_i, .chip_select_n_i, .sdi_i, .sdo_o,
   .sdo_oe_o, .reg_image_o, .serial_failure_flag_o);

// ---- test/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
   // system clock, to keep chip select edges off its sampling edge and to time the gap after each frame
   input  wire logic clk_sys_i,
   // serial link
   output logic      sclk_o,
   output logic      chip_select_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   initial begin
      sclk_o          = 1'b0;
      chip_select_n_o = 1'b1;
      sdi_o           = 1'b0;
   end

   // bit i sent is tx[63-i]; sdo seen at fall i lands in rx[63-i]
   task automatic frame(input logic [63:0] tx, input int nb,
                        output logic [63:0] rx);
      rx = '0;
      @(negedge clk_sys_i);
      chip_select_n_o = 1'b0;
      #16;
      for (int i = 0; i < nb; i++) begin
         sclk_o = 1'b1;
         sdi_o  = tx[63 - i];
         #16;
         rx[63 - i] = sdo_i;
         sclk_o     = 1'b0;
         #16;
      end
      @(negedge clk_sys_i);
      chip_select_n_o = 1'b1;
      // released line must not repeat the last bit
      sdi_o = ~sdi_o;
      repeat (8) @(negedge clk_sys_i);
   endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("unexpected %s: expected %h seen %h", nm, exp, got); \
      end \
   end
module tb;
   import spi_regport_pkg::*;
   localparam logic [7:0] MODES_OK = 8'h96;
   logic          clk_sys_i = 1'b0;
   logic          rst_i     = 1'b1;
   logic          sclk, chip_select_n, sdi, sdo, sdo_oe, flag;
   logic [1023:0] image;
   ro_status_t    ro = '0;
   event_set_t    ev = '0;
   logic [7:0]    mdl [128];
   logic [31:0]   seed = 32'hd9786d74;
   int            failures  = 0;
   int            cmp_count = 0;

   initial forever #12.5 clk_sys_i = ~clk_sys_i;

   spi_register_access_port dut_u (
      .clk_sys_i, .rst_i, .clk_en_i(1'b1), .sclk_i(sclk),
      .chip_select_n_i(chip_select_n), .sdi_i(sdi), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .ro_status_i(ro), .event_set_i(ev),
      .reg_image_o(image), .serial_failure_flag_o(flag));
   spi_host_model host_u (.clk_sys_i, .sclk_o(sclk),
      .chip_select_n_o(chip_select_n), .sdi_o(sdi), .sdo_i(sdo));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // writable bits of the registers this bench writes
   function automatic logic [7:0] wmask(input logic [6:0] a);
      case (a)
         7'h01: return 8'h3f;
         7'h02: return 8'h07;
         7'h04: return 8'h4f;
         7'h05: return 8'h7f;
         7'h0a: return 8'h7f;
         7'h06, 7'h07, 7'h08, 7'h09, 7'h27, 7'h28, 7'h29: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction

   task automatic mdl_reset();
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[7'h03] = ro.mode_status;
      mdl[7'h22] = ro.can_status;
      mdl[7'h24] = ro.lin_status;
      mdl[7'h33] = ro.bus_fault;
      mdl[7'h38] = ro.wd_status;
      mdl[7'h4b] = ro.pin_wake;
      mdl[7'h60] = ro.global_summary;
   endtask

   // one burst of hardware events while idle; sets land in sticky bytes
   task automatic pulse_events();
      logic [63:0] x;
      x = {rnd(), rnd()};
      @(negedge clk_sys_i);
      ev = x[55:0];
      @(negedge clk_sys_i);
      ev = '0;
      mdl[7'h35] = mdl[7'h35] | (x[55:48] & 8'h01);
      mdl[7'h61] = mdl[7'h61] | (x[47:40] & 8'hd3);
      mdl[7'h62] = mdl[7'h62] | (x[39:32] & 8'h0f);
      mdl[7'h63] = mdl[7'h63] | (x[31:24] & 8'h7f);
      mdl[7'h64] = mdl[7'h64] | (x[23:16] & 8'h07);
      mdl[7'h65] = mdl[7'h65] | (x[15:8] & 8'h03);
      mdl[7'h66] = mdl[7'h66] | x[7:0];
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one frame against the model: every sdo bit, then the whole image
   task automatic xfer(input logic [6:0] a, input logic rd, input int nb,
                       input logic [23:0] d);
      logic [63:0] tx;
      logic [63:0] rx;
      logic [7:0]  b;
      logic        e;
      logic        en;
      logic        bad;
      int          ad;
      tx  = {a, rd, d, rnd()};
      en  = mdl[7'h04][1];
      bad = !(nb == 16 || nb == 24 || nb == 32);
      host_u.frame(tx, nb, rx);
      for (int i = 0; i < nb; i++) begin
         ad = a + i / 8 - 1;
         if (i < 8)
            e = 1'b0;
         else if (i < 32)
            e = (ad > 127) ? 1'b0 : mdl[ad][7 - i % 8];
         else
            e = rd & tx[64 - i];
         `CHK("sdo bit", rx[63 - i], e)
      end
      if (!rd && !bad) begin
         for (int j = 0; j < nb / 8 - 1; j++) begin
            ad = a + j;
            b  = tx[55 - 8 * j -: 8];
            if (ad > 127)
               continue;
            if (ad >= 1 && ad <= 7 && mdl[7'h0a][ad - 1])
               bad = 1'b1;
            else if (ad == 1 && !MODES_OK[b[2:0]])
               bad = 1'b1;
            else if (ad == 'h61)
               mdl[ad] = mdl[ad] & ~b;
            else
               mdl[ad] = (mdl[ad] & ~wmask(7'(ad))) | (b & wmask(7'(ad)));
         end
      end
      // set after the clear: a fault in a clearing frame still shows
      if (bad && en)
         mdl[7'h61][1] = 1'b1;
      foreach (mdl[k]) `CHK("register", image[8 * k +: 8], mdl[k])
      `CHK("failure flag", flag, mdl[7'h61][1])
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys_i);
      failures++;
      close_out();
   end

   initial begin
      logic [63:0] x;
      logic [31:0] d;
      x  = {rnd(), rnd()};
      ro = x[55:0] & 56'he1f90303fe02bf;
      repeat (8) @(negedge clk_sys_i);
      rst_i = 1'b0;
      mdl_reset();
      repeat (3) @(negedge clk_sys_i);
      d = rnd();
      xfer(7'h01, 1'b1, 16, 24'h000000);
      xfer(7'h04, 1'b0, 16, 24'h020000);
      xfer(7'h06, 1'b0, 32, d[23:0]);
      xfer(7'h06, 1'b1, 32, 24'h000000);
      xfer(7'h27, 1'b0, 24, d[31:8]);
      xfer(7'h7e, 1'b0, 24, d[23:0]);
      xfer(7'h28, 1'b0, 20, d[23:0]);
      xfer(7'h61, 1'b0, 16, 24'h020000);
      xfer(7'h27, 1'b1, 40, d[23:0]);
      pulse_events();
      for (int m = 0; m < 8; m++) begin
         xfer(7'h61, 1'b0, 16, 24'h020000);
         xfer(7'h01, 1'b0, 16, {5'h00, 3'(m), 16'h0000});
      end
      xfer(7'h0a, 1'b0, 16, 24'h200000);
      xfer(7'h05, 1'b0, 24, {d[15:8] & 8'h7f, d[7:0], 8'h00});
      xfer(7'h07, 1'b1, 16, 24'hff0000);
      xfer(7'h22, 1'b0, 16, 24'hff0000);
      xfer(7'h22, 1'b1, 24, 24'h000000);
      xfer(7'h61, 1'b0, 16, 24'h020000);
      xfer(7'h00, 1'b0, 0, 24'h000000);
      xfer(7'h00, 1'b0, 8, 24'h000000);
      xfer(7'h04, 1'b0, 16, 24'h000000);
      xfer(7'h09, 1'b0, 30, d[23:0]);
      @(negedge clk_sys_i);
      rst_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      rst_i = 1'b0;
      mdl_reset();
      repeat (3) @(negedge clk_sys_i);
      xfer(7'h06, 1'b1, 32, 24'h000000);
      close_out();
   end
endmodule
